// *** src/erase_cmd_pkg.sv ***
// Constants shared by the chip-erase command handler and its testbench.
package erase_cmd_pkg;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h40;
  localparam logic [7:0] CMD_ERASE_ENABLE = 8'h54;
  localparam logic [3:0] NIB_COMM_ERR = 4'h8;
  localparam logic [3:0] NIB_CMD_ERR = 4'h1;
  localparam logic [7:0] ACK_NORMAL = 8'h40;
  localparam logic [7:0] ACK_ABNORMAL = 8'h41;
  localparam logic [7:0] ACK_COMM_ERR = 8'h48;
  localparam logic [7:0] EN_ABNORMAL = 8'h51;
  localparam logic [7:0] EN_COMM_ERR = 8'h58;
  localparam logic [7:0] ERASE_OK = 8'h4F;
  localparam logic [7:0] ERASE_BLANK_ERR = 8'h4C;
  localparam logic [7:0] ERASE_ABORT = 8'h47;
  localparam logic [7:0] PW_NOT_NEEDED = 8'hFF;
  localparam int PW_BYTES = 12;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] LAST_CMD_RESET = 8'h00;
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_PW = 3'b001,
    ST_SUM = 3'b010,
    ST_EN = 3'b011,
    ST_ERASE = 3'b100
  } state_t;
endpackage

// *** src/resp_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides for response bytes.
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  // Storage array; written only, never reset.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// *** src/erase_cmd_handler.sv ***
// Byte-level handler for the serial boot chip-erase sequence.
// Operation
// - UART mode: received command with error gets communication-error reply, back to wait.
// - Error replies carry code in low nibble, last command's upper nibble above.
// - Clocked I/O serial mode skips the reception-error check.
// - A supported command byte is echoed back as acknowledgement.
// - An unsupported command byte gets command-error reply, back to wait.
// - Password not required: skip verification, accept dummy bytes.
// - Target checks the checksum byte and sends an acknowledgement.
// - Checksum step: error gives 0x48, mismatch 0x41, both return to wait.
// - Password mismatch gives 0x41 and wait; match or not needed gives 0x40.
// - Erase-enable byte: error 0x58, wrong 0x51, else echo and start erase.
// - Erase result: 0x4F success, 0x4C blank-check error, 0x47 abort then wait.
`timescale 1ns/1ps
module erase_cmd_handler
  import erase_cmd_pkg::*;
#(
  parameter int PW_LEN = PW_BYTES,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Link mode: high for UART, low for clocked I/O serial.
  input wire logic uart_mode,
  // Received bytes from the serial receiver.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  output logic rx_ready,
  // Response bytes toward the serial transmitter.
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Stored password and its requirement setting.
  input wire logic [8*PW_BYTES-1:0] stored_password,
  input wire logic [7:0] pw_required_setting,
  // Erase engine.
  output logic erase_start,
  input wire logic erase_done,
  input wire logic erase_blank_err,
  input wire logic erase_aborted,
  // Sequence status.
  output logic busy
);
  state_t state_r;
  state_t state_nxt;
  logic [3:0] pw_idx_r;
  logic [7:0] sum_r;
  logic pw_bad_r;
  logic [7:0] last_cmd_r;
  logic erase_start_r;
  logic resp_valid;
  logic [7:0] resp_data;
  logic resp_ready;

  // Reception error counts only on the UART link.
  wire rx_err_eff = uart_mode && rx_error;
  wire take = rx_valid && rx_ready;
  wire pw_needed = (pw_required_setting != PW_NOT_NEEDED);
  wire [7:0] pw_expect = stored_password[8*pw_idx_r +: 8];
  wire pw_byte_bad = (rx_data != pw_expect);
  wire sum_ok = (rx_data == sum_r);
  wire last_pw = (pw_idx_r == 4'(PW_LEN-1));
  wire erase_event = (state_r == ST_ERASE) && (erase_done || erase_aborted);

  // Byte decodes and error codes; the upper nibble of an error reply repeats the last command.
  wire pw_take = take && (state_r == ST_PW);
  wire cmd_known = (rx_data == CMD_CHIP_ERASE);
  wire enable_ok = (rx_data == CMD_ERASE_ENABLE);
  wire [7:0] comm_err_code = {last_cmd_r[7:4], NIB_COMM_ERR};
  wire [7:0] cmd_err_code = {last_cmd_r[7:4], NIB_CMD_ERR};

  // Bytes are taken only while the reply path has room, so no reply is lost.
  assign rx_ready = resp_ready && (state_r != ST_ERASE);

  // Reply selection for each step of the sequence.
  always_comb begin
    resp_valid = 1'b0;
    resp_data = ACK_NORMAL;
    state_nxt = state_r;
    case (state_r)
      ST_CMD: begin
        if (take) begin
          resp_valid = 1'b1;
          if (rx_err_eff) begin
            resp_data = comm_err_code;
          end else if (cmd_known) begin
            resp_data = rx_data;
            state_nxt = ST_PW;
          end else begin
            resp_data = cmd_err_code;
          end
        end
      end
      ST_PW: begin
        if (take && last_pw) begin
          state_nxt = ST_SUM;
        end
      end
      ST_SUM: begin
        if (take) begin
          resp_valid = 1'b1;
          state_nxt = ST_CMD;
          if (rx_err_eff) begin
            resp_data = ACK_COMM_ERR;
          end else if (!sum_ok) begin
            resp_data = ACK_ABNORMAL;
          end else if (pw_needed && pw_bad_r) begin
            resp_data = ACK_ABNORMAL;
          end else begin
            resp_data = ACK_NORMAL;
            state_nxt = ST_EN;
          end
        end
      end
      ST_EN: begin
        if (take) begin
          resp_valid = 1'b1;
          state_nxt = ST_CMD;
          if (rx_err_eff) begin
            resp_data = EN_COMM_ERR;
          end else if (!enable_ok) begin
            resp_data = EN_ABNORMAL;
          end else begin
            resp_data = CMD_ERASE_ENABLE;
            state_nxt = ST_ERASE;
          end
        end
      end
      ST_ERASE: begin
        if (erase_event && resp_ready) begin
          resp_valid = 1'b1;
          state_nxt = ST_CMD;
          if (erase_aborted) begin
            resp_data = ERASE_ABORT;
          end else if (erase_blank_err) begin
            resp_data = ERASE_BLANK_ERR;
          end else begin
            resp_data = ERASE_OK;
          end
        end
      end
      default: begin
        state_nxt = ST_CMD;
      end
    endcase
  end

  // Sequence state.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_CMD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Last command byte seen, source of the upper nibble of error replies.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      last_cmd_r <= LAST_CMD_RESET;
    end else if (take && state_r == ST_CMD) begin
      last_cmd_r <= rx_data;
    end
  end

  // Password index. Index, sum and flag clear only while a command is awaited, so a
  // checksum byte that comes some cycles after the last password byte still meets them.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pw_idx_r <= '0;
    end else if (state_r == ST_CMD) begin
      pw_idx_r <= '0;
    end else if (pw_take) begin
      pw_idx_r <= pw_idx_r + 4'h1;
    end
  end

  // Running 8-bit checksum of the password bytes.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sum_r <= '0;
    end else if (state_r == ST_CMD) begin
      sum_r <= '0;
    end else if (pw_take) begin
      sum_r <= sum_r + rx_data;
    end
  end

  // Sticky mismatch flag; a receive fault on a password byte counts as a mismatch.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pw_bad_r <= 1'b0;
    end else if (state_r == ST_CMD) begin
      pw_bad_r <= 1'b0;
    end else if (pw_take) begin
      pw_bad_r <= pw_bad_r || pw_byte_bad || rx_err_eff;
    end
  end

  // One-cycle erase start after the enable byte is echoed.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      erase_start_r <= 1'b0;
    end else begin
      erase_start_r <= (state_r == ST_EN) && (state_nxt == ST_ERASE);
    end
  end

  assign erase_start = erase_start_r;
  assign busy = (state_r != ST_CMD);

  // Reply bytes queue here until the transmitter drains them.
  resp_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(resp_valid),
    .in_ready(resp_ready),
    .in_data(resp_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule

// *** testbench/erase_checker.sv ***
// Port-level checks for the chip-erase command handler.
`timescale 1ns/1ps
module erase_checker (
  // Watched ports.
  input wire logic core_clk,
  input wire logic reset,
  input wire logic uart_mode,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_error,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic erase_start,
  input wire logic erase_done,
  input wire logic erase_blank_err,
  input wire logic erase_aborted,
  input wire logic busy
);
  // Idle byte taken with an empty reply queue, its fault, and an erase result at hand.
  wire logic take = !busy && !tx_valid && rx_valid && rx_ready;
  wire logic bad = uart_mode && rx_error;
  wire logic fin = busy && !rx_ready && !tx_valid && (erase_done || erase_aborted);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  cmd_echo_a: assert property (
    take && !bad && rx_data == 8'h40 |=> busy && tx_valid && tx_data == 8'h40) else $error("no echo");
  cmd_err_a: assert property (
    take && !bad && rx_data != 8'h40 |=> !busy && tx_valid && tx_data[3:0] == 4'h1) else $error("no cmd error");
  comm_err_a: assert property (
    take && bad |=> !busy && tx_valid && tx_data[3:0] == 4'h8) else $error("no comm error");
  idle_ready_a: assert property (!busy && !tx_valid |-> rx_ready) else $error("idle refuses");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("reply lost");
  start_pulse_a: assert property (erase_start |=> !erase_start) else $error("long start");
  start_block_a: assert property (erase_start |-> busy && !rx_ready) else $error("input open");
  erase_res_a: assert property (
    fin |=> tx_valid && tx_data == ($past(erase_aborted) ? 8'h47 : $past(erase_blank_err) ? 8'h4C : 8'h4F))
    else $error("bad result");
  // Main scenarios reached.
  cover property (erase_start);
  cover property (fin && erase_aborted);
  cover property (take && bad);
endmodule
bind erase_cmd_handler erase_checker u_erase_checker (.core_clk, .reset, .uart_mode, .rx_valid, .rx_data,
  .rx_error, .rx_ready, .tx_valid, .tx_ready, .tx_data, .erase_start, .erase_done, .erase_blank_err,
  .erase_aborted, .busy);

// *** testbench/tx_sink.sv ***
// Transmitter model that takes reply bytes and can stall.
`timescale 1ns/1ps
module tx_sink (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic reset,
  // Reply bytes.
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // High holds the handler off.
  input wire logic stall
);
  logic [7:0] got[$];
  assign tx_ready = !stall;
  // Keeps each byte taken by handshake.
  always @(posedge core_clk) begin
    if (!reset && tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule

// *** testbench/erase_cmd_handler_tb.sv ***
// Self-checking bench for the chip-erase command handler.
`timescale 1ns/1ps
module erase_cmd_handler_tb;
  import erase_cmd_pkg::*;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
  logic core_clk = 0, reset = 1, uart_mode = 1, rx_valid = 0, rx_error = 0, stall = 0;
  logic [2:0] fl = 3'h0;
  logic [7:0] rx_data = 8'h00, pw_req = 8'h00, tx_data;
  logic [8*PW_BYTES-1:0] pwd = 96'h0C0B0A090807060504030201;
  logic rx_ready, tx_valid, tx_ready, erase_start, busy;
  int miscompares = 0, n_checks = 0, cycles = 0, starts = 0;
  erase_cmd_handler u_erase_cmd_handler (.core_clk, .reset, .uart_mode, .rx_valid, .rx_data, .rx_error, .rx_ready,
    .tx_valid, .tx_ready, .tx_data, .stored_password(pwd), .pw_required_setting(pw_req), .erase_start,
    .erase_done(fl[0]), .erase_blank_err(fl[1]), .erase_aborted(fl[2]), .busy);
  tx_sink u_tx_sink (.core_clk, .reset, .tx_valid, .tx_data, .tx_ready, .stall);
  // Clock of 8 ns.
  initial forever #4 core_clk = ~core_clk;
  // Cuts a hang short and counts erase start pulses.
  always @(posedge core_clk) begin
    cycles++;
    starts += erase_start;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // Offers one byte and holds it until taken.
  task automatic send(input logic [7:0] b, input logic e);
    rx_valid <= 1'b1;
    rx_data <= b;
    rx_error <= e;
    do @(posedge core_clk); while (!rx_ready);
  endtask
  // Releases the input and compares the next reply byte.
  task automatic reply(input logic [7:0] e);
    logic [7:0] v;
    if (rx_valid) rx_valid <= 1'b0;
    while (u_tx_sink.got.size() == 0) @(posedge core_clk);
    v = u_tx_sink.got.pop_front();
    `CHK("reply", e, v)
  endtask
  // Sends the password, one byte flipped if asked, idles gap cycles, then its sum plus an offset.
  task automatic pw(input int bad, input logic [7:0] adj, input logic e, input int gap);
    logic [7:0] s = 8'h00;
    logic [7:0] b;
    for (int i = 0; i < PW_BYTES; i++) begin
      b = pwd[8*i+:8] ^ ((i == bad) ? 8'h80 : 8'h00);
      s += b;
      send(b, 1'b0);
    end
    if (gap > 0) begin
      rx_valid <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
    send(s + adj, e);
  endtask
  // Fills the reply queue with FIFO_DEPTH command errors, checks that input is then refused, then drains it.
  task automatic t_fill();
    stall <= 1'b1;
    repeat (FIFO_DEPTH) send(8'h33, 1'b0);
    rx_valid <= 1'b0;
    @(posedge core_clk);
    `CHK("rx_ready", 1'b0, rx_ready)
    stall <= 1'b0;
    reply(8'h01);
    repeat (FIFO_DEPTH - 1) reply(8'h31);
  endtask
  // Receive faults, bad sums, bad passwords and a wrong enable byte.
  task automatic t_errors();
    send(8'h40, 1'b1);
    reply(8'h38);
    uart_mode <= 1'b0;
    send(8'h40, 1'b1);
    reply(8'h40);
    uart_mode <= 1'b1;
    pw(-1, 8'h00, 1'b1, 0);
    reply(8'h48);
    send(8'h40, 1'b0);
    reply(8'h40);
    pw(-1, 8'h01, 1'b0, 0);
    reply(8'h41);
    send(8'h40, 1'b0);
    reply(8'h40);
    pw(3, 8'h00, 1'b0, 0);
    reply(8'h41);
    pw_req <= PW_NOT_NEEDED;
    send(8'h40, 1'b0);
    reply(8'h40);
    pw(3, 8'h00, 1'b0, 0);
    reply(8'h40);
    send(8'h55, 1'b0);
    reply(8'h51);
    pw_req <= 8'h00;
    send(8'h40, 1'b0);
    reply(8'h40);
    pw(-1, 8'h00, 1'b0, 0);
    reply(8'h40);
    send(CMD_ERASE_ENABLE, 1'b1);
    reply(8'h58);
    send(8'h77, 1'b0);
    reply(8'h41);
  endtask
  // Full sequence ending in the given engine result, with a late checksum and a stalled transmitter.
  task automatic t_erase(input logic [2:0] f, input logic [7:0] res);
    int s0 = starts;
    send(CMD_CHIP_ERASE, 1'b0);
    reply(8'h40);
    pw(-1, 8'h00, 1'b0, 2);
    reply(8'h40);
    send(CMD_ERASE_ENABLE, 1'b0);
    reply(8'h54);
    fl <= f;
    stall <= 1'b1;
    repeat (4) @(posedge core_clk);
    stall <= 1'b0;
    reply(res);
    fl <= 3'h0;
    `CHK("starts", s0 + 1, starts)
    `CHK("busy", 1'b0, busy)
  endtask
  // Reset in mid-sequence drops the queued echo and the last command, and the handler idles.
  task automatic t_reset();
    stall <= 1'b1;
    send(CMD_CHIP_ERASE, 1'b0);
    rx_valid <= 1'b0;
    @(posedge core_clk);
    `CHK("busy", 1'b1, busy)
    reset <= 1'b1;
    @(posedge core_clk);
    `CHK("busy", 1'b0, busy)
    `CHK("tx_valid", 1'b0, tx_valid)
    `CHK("rx_ready", 1'b1, rx_ready)
    reset <= 1'b0;
    stall <= 1'b0;
    @(posedge core_clk);
    send(8'h77, 1'b0);
    reply(8'h01);
  endtask
  // Prints the verdict and ends the run.
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_fill();
    t_errors();
    t_erase(3'b001, 8'h4F);
    t_erase(3'b011, 8'h4C);
    t_erase(3'b110, 8'h47);
    t_reset();
    give_verdict();
  end
endmodule
